// ---- cap_sense_cfg.svh ----
`ifndef CAP_SENSE_CFG_SVH
`define CAP_SENSE_CFG_SVH
// register offsets in the special function register space
`define OFS_SCAN_START      8'h92
`define OFS_SCAN_END        8'h93
`define OFS_THRESH_LOW      8'h96
`define OFS_THRESH_HIGH     8'h97
`define OFS_PIN_MONITOR     8'h9F
// reset values
`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
// pin monitor field positions
`define PM_SERIAL_TX        7
`define PM_SPI_OUT          6
`define PM_SMBUS            5
`define PM_COUNTER_ARRAY    4
`define PM_PORT_LATCH       3
`define PM_COMPARATOR       2
// retry limits per policy
`define RETRY_LIMIT_TWICE   3'h2
`define RETRY_LIMIT_FOUR    3'h4
// start-of-conversion mode that means auto-scan
`define MODE_AUTO_SCAN      3'h7
`endif

// ---- cap_sense_pkg.sv ----
`default_nettype none
package cap_sense_pkg;
  // retry policy encodings
  typedef enum logic [1:0] {
    RETRY_ALWAYS = 2'h0,
    RETRY_TWICE  = 2'h1,
    RETRY_FOUR   = 2'h2,
    RETRY_RSVD   = 2'h3
  } retry_policy_e;

  // register bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // one result from the conversion core
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } conv_result_s;

  // scan states, one-hot
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN  = 2'b10
  } scan_state_e;
endpackage : cap_sense_pkg
`default_nettype wire

// ---- cap_sense_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cap_sense_cfg.svh"

module cap_sense_unit (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // register access
  input  wire cap_sense_pkg::sfr_req_s     sfr_req,
  output logic [7:0]                       sfr_rdata,
  // loose control bits held elsewhere
  input  wire logic [2:0]                  conversion_start_mode,
  input  wire logic                        conversion_busy_set,
  input  wire logic                        conversion_stop,
  input  wire logic                        threshold_compare_enable,
  input  wire logic                        threshold_flag_clear,
  input  wire logic                        retry_flag_clear,
  // conversion core
  input  wire cap_sense_pkg::conv_result_s conv_result,
  input  wire logic                        bit_cycle_end,
  output logic [5:0]                       channel_mux_select,
  output logic                             bit_retry,
  output logic                             scan_active,
  output logic                             threshold_exceeded_flag,
  output logic                             retry_event_flag,
  // monitored peripheral signals, same clock
  input  wire logic                        serial_tx_out,
  input  wire logic [3:0]                  spi_out,
  input  wire logic [1:0]                  smbus_out,
  input  wire logic [2:0]                  counter_array_out,
  input  wire logic                        port_latch_write,
  input  wire logic                        analog_comparator_sync
);

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [5:0]  scan_start_channel;
  logic [5:0]  scan_end_channel;
  logic [7:0]  compare_threshold_low;
  logic [7:0]  compare_threshold_high;
  logic [7:0]  pin_monitor_control;
  logic [10:0] mon_prev;
  logic [2:0]  retry_count;
  cap_sense_pkg::scan_state_e scan_state;

  // address decode
  wire wr_start  = sfr_req.wr && (sfr_req.addr == `OFS_SCAN_START);
  wire wr_end    = sfr_req.wr && (sfr_req.addr == `OFS_SCAN_END);
  wire wr_th_low = sfr_req.wr && (sfr_req.addr == `OFS_THRESH_LOW);
  wire wr_th_hi  = sfr_req.wr && (sfr_req.addr == `OFS_THRESH_HIGH);
  wire wr_pm     = sfr_req.wr && (sfr_req.addr == `OFS_PIN_MONITOR);
  wire auto_mode = (conversion_start_mode == `MODE_AUTO_SCAN);

  // register writes; upper start/end bits simply not stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scan_start_channel     <= 6'h00;
      scan_end_channel       <= 6'h00;
      compare_threshold_low  <= `RST_BYTE;
      compare_threshold_high <= `RST_BYTE;
      pin_monitor_control    <= `RST_BYTE;
    end else begin
      if (wr_start) scan_start_channel <= sfr_req.wdata[5:0];
      if (wr_end) scan_end_channel <= sfr_req.wdata[5:0];
      if (wr_th_low) compare_threshold_low <= sfr_req.wdata;
      if (wr_th_hi) compare_threshold_high <= sfr_req.wdata;
      if (wr_pm) pin_monitor_control <= sfr_req.wdata;
    end
  end

  // read mux; unmapped offsets read zero
  // upper start/end bits read zero
  wire [7:0] next_rdata =
    (sfr_req.addr == `OFS_SCAN_START)  ? {2'b00, scan_start_channel} :
    (sfr_req.addr == `OFS_SCAN_END)    ? {2'b00, scan_end_channel} :
    (sfr_req.addr == `OFS_THRESH_LOW)  ? compare_threshold_low :
    (sfr_req.addr == `OFS_THRESH_HIGH) ? compare_threshold_high :
    (sfr_req.addr == `OFS_PIN_MONITOR) ? pin_monitor_control : 8'h00;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) sfr_rdata <= 8'h00;
    else if (sfr_req.rd) sfr_rdata <= next_rdata;
  end

  // -------------------------------------------------------------
  // auto-scan sequencing
  // -------------------------------------------------------------
  wire conv_done = conv_result.valid;
  wire at_end    = (channel_mux_select == scan_end_channel);

  // scan runs continuously once busy is written in mode 111
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scan_state         <= cap_sense_pkg::SCAN_IDLE;
      scan_active        <= 1'b0;
      channel_mux_select <= 6'h00;
    end else begin
      case (scan_state)
        cap_sense_pkg::SCAN_IDLE: begin
          if (auto_mode && conversion_busy_set) begin
            scan_state         <= cap_sense_pkg::SCAN_RUN;
            scan_active        <= 1'b1;
            channel_mux_select <= scan_start_channel;
          end
        end
        cap_sense_pkg::SCAN_RUN: begin
          if (!auto_mode || conversion_stop) begin
            scan_state  <= cap_sense_pkg::SCAN_IDLE;
            scan_active <= 1'b0;
          end else if (conv_done) begin
            channel_mux_select <= at_end ? scan_start_channel
                                         : channel_mux_select + 6'h01;
          end
        end
        default: begin
          scan_state  <= cap_sense_pkg::SCAN_IDLE;
          scan_active <= 1'b0;
        end
      endcase
      if (auto_mode && wr_start) channel_mux_select <= sfr_req.wdata[5:0];
    end
  end

  // -------------------------------------------------------------
  // digital comparator
  // -------------------------------------------------------------
  // threshold assembly
  wire [15:0] threshold = {compare_threshold_high, compare_threshold_low};
  // compare once per conversion when enabled
  wire over = threshold_compare_enable && conv_done && (conv_result.value > threshold);

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) threshold_exceeded_flag <= 1'b0;
    else if (over) threshold_exceeded_flag <= 1'b1;
    else if (threshold_flag_clear) threshold_exceeded_flag <= 1'b0;
  end

  // -------------------------------------------------------------
  // pin monitor
  // -------------------------------------------------------------
  wire [10:0] mon_now = {serial_tx_out, spi_out, smbus_out,
                         counter_array_out, analog_comparator_sync};
  wire [10:0] mon_chg = mon_now ^ mon_prev;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) mon_prev <= 11'h000;
    else mon_prev <= mon_now;
  end

  wire ev_tx   = pin_monitor_control[`PM_SERIAL_TX] && mon_chg[10];
  wire ev_spi  = pin_monitor_control[`PM_SPI_OUT] && |mon_chg[9:6];
  wire ev_smb  = pin_monitor_control[`PM_SMBUS] && |mon_chg[5:4];
  wire ev_pca  = pin_monitor_control[`PM_COUNTER_ARRAY] && |mon_chg[3:1];
  wire ev_port = pin_monitor_control[`PM_PORT_LATCH] && port_latch_write;
  wire ev_cmp  = pin_monitor_control[`PM_COMPARATOR] && mon_chg[0];
  wire mon_event = ev_tx | ev_spi | ev_smb | ev_pca | ev_port | ev_cmp;

  // retry limit from the policy field
  wire cap_sense_pkg::retry_policy_e policy =
    cap_sense_pkg::retry_policy_e'(pin_monitor_control[1:0]);
  wire retry_ok =
    (policy == cap_sense_pkg::RETRY_ALWAYS) ? 1'b1 :
    (policy == cap_sense_pkg::RETRY_TWICE)  ? (retry_count < `RETRY_LIMIT_TWICE) :
    (policy == cap_sense_pkg::RETRY_FOUR)   ? (retry_count < `RETRY_LIMIT_FOUR) :
    1'b0;
  wire next_retry = mon_event && retry_ok && bit_cycle_end;

  // count consecutive retried bit cycles; a clean cycle resets it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      retry_count <= 3'h0;
      bit_retry   <= 1'b0;
    end else begin
      bit_retry <= next_retry;
      if (bit_cycle_end) begin
        if (next_retry) retry_count <= retry_count + 3'h1;
        else if (!mon_event) retry_count <= 3'h0;
      end
      // new policy starts clean, so an old run cannot break its limit
      if (wr_pm) retry_count <= 3'h0;
    end
  end

  // retry status flag, set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) retry_event_flag <= 1'b0;
    else if (next_retry) retry_event_flag <= 1'b1;
    else if (retry_flag_clear) retry_event_flag <= 1'b0;
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_start_mirror: assert property (@(posedge clk_sys) disable iff (!nrst)
    auto_mode && wr_start |=> channel_mux_select == $past(sfr_req.wdata[5:0]))
    else $error("start write did not reach mux");
  a_start_upper: assert property (@(posedge clk_sys) disable iff (!nrst)
    sfr_req.rd && sfr_req.addr == `OFS_SCAN_START |=> sfr_rdata[7:6] == 2'b00)
    else $error("start upper bits not zero");
  a_scan_begin: assert property (@(posedge clk_sys) disable iff (!nrst)
    scan_state == cap_sense_pkg::SCAN_IDLE && auto_mode && conversion_busy_set
    && !wr_start |=> scan_active && channel_mux_select == $past(scan_start_channel))
    else $error("scan did not start at first channel");
  a_scan_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    scan_active && auto_mode && !conversion_stop && conv_done && at_end && !wr_start
    |=> channel_mux_select == $past(scan_start_channel))
    else $error("scan did not wrap after last channel");
  a_cmp_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    threshold_compare_enable && conv_done && conv_result.value > threshold
    |=> threshold_exceeded_flag)
    else $error("compare flag not set");
  a_cmp_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    threshold_exceeded_flag && !threshold_flag_clear |=> threshold_exceeded_flag)
    else $error("compare flag dropped without clear");
  a_cmp_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !threshold_compare_enable && !threshold_exceeded_flag |=> !threshold_exceeded_flag)
    else $error("compare flag set while disabled");
  a_retry_twice: assert property (@(posedge clk_sys) disable iff (!nrst)
    policy == cap_sense_pkg::RETRY_TWICE |-> retry_count <= `RETRY_LIMIT_TWICE)
    else $error("twice policy exceeded");
  a_retry_four: assert property (@(posedge clk_sys) disable iff (!nrst)
    policy == cap_sense_pkg::RETRY_FOUR |-> retry_count <= `RETRY_LIMIT_FOUR)
    else $error("four policy exceeded");
  a_retry_always: assert property (@(posedge clk_sys) disable iff (!nrst)
    policy == cap_sense_pkg::RETRY_ALWAYS && mon_event && bit_cycle_end
    |=> bit_retry && retry_event_flag)
    else $error("always policy missed a retry");
  a_port_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_PORT_LATCH] && port_latch_write && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("port latch write not monitored");
  a_thresh_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_th_hi |=> threshold[15:8] == $past(sfr_req.wdata))
    else $error("threshold high byte not loaded");
  a_thresh_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_th_low |=> threshold[7:0] == $past(sfr_req.wdata))
    else $error("threshold low byte not loaded");
  a_tx_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_SERIAL_TX] && $changed(serial_tx_out) && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("serial transmit change not monitored");
  a_spi_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_SPI_OUT] && $changed(spi_out) && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("spi output change not monitored");
  a_smbus_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_SMBUS] && $changed(smbus_out) && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("smbus pin change not monitored");
  a_counter_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_COUNTER_ARRAY] && $changed(counter_array_out) && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("counter array change not monitored");
  a_comparator_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_monitor_control[`PM_COMPARATOR] && $changed(analog_comparator_sync) && bit_cycle_end
    && policy == cap_sense_pkg::RETRY_ALWAYS |=> bit_retry)
    else $error("comparator change not monitored");
  a_retry_status: assert property (@(posedge clk_sys) disable iff (!nrst)
    bit_retry |-> retry_event_flag)
    else $error("retry without status flag");
  a_retry_origin: assert property (@(posedge clk_sys) disable iff (!nrst)
    bit_retry |-> $past(bit_cycle_end))
    else $error("retry not tied to a bit cycle end");
  a_retry_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
    policy == cap_sense_pkg::RETRY_RSVD |=> !bit_retry)
    else $error("reserved policy retried");
  a_scan_advance: assert property (@(posedge clk_sys) disable iff (!nrst)
    scan_active && auto_mode && !conversion_stop && conv_done && !at_end && !wr_start
    |=> channel_mux_select == $past(channel_mux_select) + 6'h01)
    else $error("scan did not advance one channel");

endmodule : cap_sense_unit
`default_nettype wire

// ---- cap_sense_unit_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cap_sense_cfg.svh"

module cap_sense_unit_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                        clk_sys;
  logic                        nrst;
  cap_sense_pkg::sfr_req_s     req;
  cap_sense_pkg::conv_result_s cres;
  logic [7:0]                  rdata;
  logic [5:0]                  mux;
  logic [2:0]                  mode;
  logic                        busy, stop, en, tclr, rclr, bce, retry, active, tflag, rflag;
  logic                        stx, plw, acmp;
  logic [3:0]                  spi;
  logic [1:0]                  smb;
  logic [2:0]                  cnt;
  int                          errors;
  int                          n_tests;

  cap_sense_unit cap_sense_unit_inst (
    .clk_sys(clk_sys), .nrst(nrst), .sfr_req(req), .sfr_rdata(rdata),
    .conversion_start_mode(mode), .conversion_busy_set(busy), .conversion_stop(stop),
    .threshold_compare_enable(en), .threshold_flag_clear(tclr), .retry_flag_clear(rclr),
    .conv_result(cres), .bit_cycle_end(bce), .channel_mux_select(mux), .bit_retry(retry),
    .scan_active(active), .threshold_exceeded_flag(tflag), .retry_event_flag(rflag),
    .serial_tx_out(stx), .spi_out(spi), .smbus_out(smb), .counter_array_out(cnt),
    .port_latch_write(plw), .analog_comparator_sync(acmp)
  );

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // one-cycle strobe, changed only at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys) req.wr = 1'b0;
  endtask : wr

  // read data is registered, so look one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys) req.rd = 1'b0;
    @(negedge clk_sys) chk("sfr_rdata", 16'(rdata), 16'(e));
  endtask : rd_chk

  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
  endtask : pulse

  task automatic conv(input logic [15:0] v);
    @(negedge clk_sys) cres = '{valid: 1'b1, value: v};
    @(negedge clk_sys) cres.valid = 1'b0;
  endtask : conv

  // a bit cycle that ends with no event restarts the retry count
  task automatic quiet();
    @(negedge clk_sys) bce = 1'b1;
    @(negedge clk_sys) bce = 1'b0;
    chk("bit_retry", 16'(retry), 16'h0000);
  endtask : quiet

  // change one monitored source in the cycle that ends a bit cycle
  task automatic mon_ev(input int src, input logic exp);
    @(negedge clk_sys);
    bce = 1'b1;
    case (src)
      0: stx = ~stx;
      1: spi = ~spi;
      2: smb = ~smb;
      3: cnt = ~cnt;
      4: plw = 1'b1;
      default: acmp = ~acmp;
    endcase
    @(negedge clk_sys);
    bce = 1'b0;
    plw = 1'b0;
    chk("bit_retry", 16'(retry), 16'(exp));
    @(negedge clk_sys) chk("bit_retry", 16'(retry), 16'h0000);
  endtask : mon_ev

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {busy, stop, en, tclr, rclr, bce, stx, plw, acmp, spi, smb, cnt, mode} = '0;
    req = '0;
    cres = '0;
    errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    rd_chk(`OFS_SCAN_START, `RST_BYTE);
    rd_chk(`OFS_PIN_MONITOR, `RST_BYTE);
    wr(`OFS_SCAN_START, 8'hFF);
    rd_chk(`OFS_SCAN_START, 8'h3F);
    chk("channel_mux_select", 16'(mux), 16'h0000);
    wr(`OFS_SCAN_END, 8'hFF);
    rd_chk(`OFS_SCAN_END, 8'h3F);
    wr(8'h94, 8'h5A);
    rd_chk(8'h94, 8'h00);
    wr(`OFS_THRESH_HIGH, 8'h12);
    wr(`OFS_THRESH_LOW, 8'h34);
    rd_chk(`OFS_THRESH_HIGH, 8'h12);
    rd_chk(`OFS_THRESH_LOW, 8'h34);
    wr(`OFS_PIN_MONITOR, 8'hA5);
    rd_chk(`OFS_PIN_MONITOR, 8'hA5);
    wr(`OFS_SCAN_START, 8'h02);
    wr(`OFS_SCAN_END, 8'h04);
    mode = `MODE_AUTO_SCAN;
    pulse(busy);
    chk("scan_active", 16'(active), 16'h0001);
    chk("channel_mux_select", 16'(mux), 16'h0002);
    for (int i = 0; i < 3; i++) begin
      conv(16'h0000);
      chk("channel_mux_select", 16'(mux), (i == 2) ? 16'h0002 : 16'(3 + i));
    end
    wr(`OFS_SCAN_START, 8'h05);
    chk("channel_mux_select", 16'(mux), 16'h0005);
    pulse(stop);
    chk("scan_active", 16'(active), 16'h0000);
    mode = 3'h0;
    pulse(busy);
    chk("scan_active", 16'(active), 16'h0000);
    conv(16'hFFFF);
    chk("threshold_exceeded_flag", 16'(tflag), 16'h0000);
    en = 1'b1;
    conv(16'h1234);
    chk("threshold_exceeded_flag", 16'(tflag), 16'h0000);
    conv(16'h1235);
    chk("threshold_exceeded_flag", 16'(tflag), 16'h0001);
    conv(16'h0000);
    chk("threshold_exceeded_flag", 16'(tflag), 16'h0001);
    pulse(tclr);
    chk("threshold_exceeded_flag", 16'(tflag), 16'h0000);
    // each source alone, then all but it
    for (int s = 0; s < 6; s++) begin
      wr(`OFS_PIN_MONITOR, 8'h80 >> s);
      mon_ev(s, 1'b1);
      chk("retry_event_flag", 16'(rflag), 16'h0001);
      pulse(rclr);
      chk("retry_event_flag", 16'(rflag), 16'h0000);
      wr(`OFS_PIN_MONITOR, ~(8'h80 >> s) & 8'hFC);
      mon_ev(s, 1'b0);
    end
    for (int p = 0; p < 4; p++) begin
      wr(`OFS_PIN_MONITOR, 8'h40 | 8'(p));
      quiet();
      for (int k = 0; k < 6; k++) begin
        mon_ev(1, (p == 0) || (p == 1 && k < 2) || (p == 2 && k < 4));
      end
    end
    test_done();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    test_done();
  end
endmodule : cap_sense_unit_tb
`default_nettype wire
